// [hw/eols_top.v]
// eols_top.v: appends a line-statistics trailer after each video line
// assumes: pixel stream and line valid are sampled on pix_clk rising edges;
// pix_clk is slow against mclk; config inputs are quasi-static
//
// Functional notes
// R1: trailer enable input turns trailer on/off
// R2: first three words aa, 55, aa
// R3: line valid low through whole trailer
// R4: word four low nibble line counter
// R5: area mode puts row counter upper nibble
// R6: words five-nine line sum, low slice first
// R7: words ten-twelve above-threshold count, low first
// R8: words thirteen-fifteen below-threshold count, low first
// R9: words sixteen-twenty differential sum, low first
// R10: only region-of-interest pixels are counted
// R11: upper threshold twelve bits, 0 to 4095
// R12: lower threshold twelve bits, 0 to 4095
// R13: strict compares, absolute adjacent differences
// R14: twenty words right after line, counters wrap
`timescale 1ns/1ns
`default_nettype none
`include "eols_regs.vh"
module eols_top #(
    parameter PIX_W = 12,
    parameter COL_W = 16
) (
    // clock and reset
    input wire mclk,
    input wire arst_n,
    // video in (pixel clock domain, sampled here)
    input wire pix_clk,
    input wire lval_in,
    input wire [PIX_W-1:0] pix_in,
    // configuration
    input wire trailer_en,
    input wire area_mode,
    input wire [PIX_W-1:0] thr_upper,
    input wire [PIX_W-1:0] thr_lower,
    input wire [COL_W-1:0] roi_first,
    input wire [COL_W-1:0] roi_last,
    // video out, one word per pixel clock edge
    output reg lval_out,
    output reg [PIX_W-1:0] pix_out,
    output reg word_stb
);
    // ************************************************
    // pixel clock edge detection
    // ************************************************
    wire pclk_s;
    reg pclk_q;
    eols_sync u_sync (
        .mclk(mclk),
        .arst_n(arst_n),
        .d(pix_clk),
        .q(pclk_s)
    );
    // config levels come from the control side's clock; two stages keep a
    // change from being seen half-way through a trailer decision
    wire trl_en_s;
    wire area_s;
    eols_sync u_sync_en (
        .mclk(mclk),
        .arst_n(arst_n),
        .d(trailer_en),
        .q(trl_en_s)
    );
    eols_sync u_sync_area (
        .mclk(mclk),
        .arst_n(arst_n),
        .d(area_mode),
        .q(area_s)
    );
    // data and lval are held stable around the pixel edge, so a two-stage
    // sample is enough; sampling them on the same delay keeps them aligned
    reg lval_m_q, lval_s_q;
    reg [PIX_W-1:0] pix_m_q, pix_s_q;
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pclk_q <= 1'b0;
            lval_m_q <= 1'b0;
            lval_s_q <= 1'b0;
            pix_m_q <= {PIX_W{1'b0}};
            pix_s_q <= {PIX_W{1'b0}};
        end else begin
            pclk_q <= pclk_s;
            lval_m_q <= lval_in;
            lval_s_q <= lval_m_q;
            pix_m_q <= pix_in;
            pix_s_q <= pix_m_q;
        end
    end
    wire pedge = pclk_s & ~pclk_q;

    // ************************************************
    // statistics accumulation
    // ************************************************
    reg lval_d1_q;
    reg [COL_W-1:0] col_q;
    reg [PIX_W-1:0] prev_q;
    reg have_prev_q;
    reg [`EOLS_ACC_W-1:0] sum_q, dif_q;
    reg [`EOLS_CNT_ACC_W-1:0] abv_q, blw_q;
    reg [`EOLS_CNT_W-1:0] line_cnt_q, row_cnt_q;
    reg busy_q;
    reg [4:0] idx_q;
    reg [`EOLS_ACC_W-1:0] sum_h_q, dif_h_q;
    reg [`EOLS_CNT_ACC_W-1:0] abv_h_q, blw_h_q;
    reg [7:0] cnt_word_q;

    wire in_roi = (col_q >= roi_first) && (col_q <= roi_last); // R10
    wire [PIX_W-1:0] diff_abs = (pix_s_q >= prev_q) ? (pix_s_q - prev_q) : (prev_q - pix_s_q); // R13
    wire line_end = lval_d1_q & ~lval_s_q;

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            lval_d1_q <= 1'b0;
            col_q <= {COL_W{1'b0}};
            prev_q <= {PIX_W{1'b0}};
            have_prev_q <= 1'b0;
            sum_q <= {`EOLS_ACC_W{1'b0}};
            dif_q <= {`EOLS_ACC_W{1'b0}};
            abv_q <= {`EOLS_CNT_ACC_W{1'b0}};
            blw_q <= {`EOLS_CNT_ACC_W{1'b0}};
        end else if (pedge) begin
            lval_d1_q <= lval_s_q;
            if (lval_s_q) begin
                col_q <= col_q + {{(COL_W-1){1'b0}}, 1'b1};
                if (in_roi) begin // R10
                    sum_q <= sum_q + {{(`EOLS_ACC_W-PIX_W){1'b0}}, pix_s_q}; // R6
                    if (pix_s_q > thr_upper) // R7 R11 R13
                        abv_q <= abv_q + {{(`EOLS_CNT_ACC_W-1){1'b0}}, 1'b1};
                    if (pix_s_q < thr_lower) // R8 R12 R13
                        blw_q <= blw_q + {{(`EOLS_CNT_ACC_W-1){1'b0}}, 1'b1};
                    if (have_prev_q) // R9
                        dif_q <= dif_q + {{(`EOLS_ACC_W-PIX_W){1'b0}}, diff_abs};
                    prev_q <= pix_s_q;
                    have_prev_q <= 1'b1;
                end
            end else begin
                col_q <= {COL_W{1'b0}};
                have_prev_q <= 1'b0;
                if (line_end) begin
                    sum_q <= {`EOLS_ACC_W{1'b0}};
                    dif_q <= {`EOLS_ACC_W{1'b0}};
                    abv_q <= {`EOLS_CNT_ACC_W{1'b0}};
                    blw_q <= {`EOLS_CNT_ACC_W{1'b0}};
                end
            end
        end
    end

    // ************************************************
    // trailer sequencer
    // ************************************************
    // a new line arriving during the trailer is lost: the trailer owns the
    // 20 pixel clocks after lval falls, the sender must leave that gap
    // word 0 leaves on the line-end edge itself, so the sequencer walks 1..19
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            busy_q <= 1'b0;
            idx_q <= 5'h00;
            line_cnt_q <= `EOLS_CNT_RST;
            row_cnt_q <= `EOLS_CNT_RST;
            sum_h_q <= {`EOLS_ACC_W{1'b0}};
            dif_h_q <= {`EOLS_ACC_W{1'b0}};
            abv_h_q <= {`EOLS_CNT_ACC_W{1'b0}};
            blw_h_q <= {`EOLS_CNT_ACC_W{1'b0}};
            cnt_word_q <= 8'h00;
        end else if (pedge) begin
            if (line_end) begin
                line_cnt_q <= line_cnt_q + 4'h1; // R4 R14
                row_cnt_q <= row_cnt_q + 4'h1; // R5 R14
                cnt_word_q <= {(area_s ? row_cnt_q : 4'h0), line_cnt_q}; // R4 R5
                sum_h_q <= sum_q;
                dif_h_q <= dif_q;
                abv_h_q <= abv_q;
                blw_h_q <= blw_q;
                busy_q <= trl_en_s; // R1 R14
                idx_q <= `EOLS_LOC_PAT2; // R14
            end else if (busy_q) begin
                if (idx_q == `EOLS_TRL_LEN - 5'h01)
                    busy_q <= 1'b0;
                idx_q <= idx_q + 5'h01;
            end
        end
    end

    // ************************************************
    // output word select
    // ************************************************
    reg [`EOLS_SLICE_W-1:0] word;
    always @* begin
        word = `EOLS_PAT_A;
        if (idx_q == `EOLS_LOC_PAT2)
            word = `EOLS_PAT_5; // R2
        else if (idx_q == `EOLS_LOC_CNT)
            word = cnt_word_q;
        else if (idx_q >= `EOLS_LOC_DIF)
            word = dif_h_q[(idx_q - `EOLS_LOC_DIF) * `EOLS_SLICE_W +: `EOLS_SLICE_W]; // R9
        else if (idx_q >= `EOLS_LOC_BLW)
            word = blw_h_q[(idx_q - `EOLS_LOC_BLW) * `EOLS_SLICE_W +: `EOLS_SLICE_W]; // R8
        else if (idx_q >= `EOLS_LOC_ABV)
            word = abv_h_q[(idx_q - `EOLS_LOC_ABV) * `EOLS_SLICE_W +: `EOLS_SLICE_W]; // R7
        else if (idx_q >= `EOLS_LOC_SUM)
            word = sum_h_q[(idx_q - `EOLS_LOC_SUM) * `EOLS_SLICE_W +: `EOLS_SLICE_W]; // R6
    end

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            lval_out <= 1'b0;
            pix_out <= {PIX_W{1'b0}};
            word_stb <= 1'b0;
        end else begin
            word_stb <= pedge;
            if (pedge) begin
                if (line_end && trl_en_s) begin
                    // first pattern word follows the last line word with no gap
                    lval_out <= 1'b0; // R3
                    pix_out <= {{(PIX_W-`EOLS_SLICE_W){1'b0}}, `EOLS_PAT_A}; // R2 R14
                end else if (busy_q) begin
                    lval_out <= 1'b0; // R3
                    pix_out <= {{(PIX_W-`EOLS_SLICE_W){1'b0}}, word}; // R2 R14
                end else begin
                    lval_out <= lval_s_q;
                    pix_out <= pix_s_q;
                end
            end
        end
    end
endmodule // eols_top
`default_nettype wire

// [hw/eols_regs.vh]
// eols_regs.vh: constants for the end-of-line statistics trailer
// assumes: included by bare name from files under hw/
`ifndef EOLS_REGS_VH
`define EOLS_REGS_VH
`define EOLS_PAT_A 8'haa
`define EOLS_PAT_5 8'h55
`define EOLS_TRL_LEN 5'h14
`define EOLS_LOC_PAT1 5'h00
`define EOLS_LOC_PAT2 5'h01
`define EOLS_LOC_PAT3 5'h02
`define EOLS_LOC_CNT 5'h03
`define EOLS_LOC_SUM 5'h04
`define EOLS_LOC_ABV 5'h09
`define EOLS_LOC_BLW 5'h0c
`define EOLS_LOC_DIF 5'h0f
`define EOLS_SLICE_W 8
`define EOLS_CNT_W 4
`define EOLS_ACC_W 40
`define EOLS_CNT_ACC_W 24
`define EOLS_CNT_RST 4'h0
`endif

// [hw/eols_sync.v]
// eols_sync.v: two-flip-flop synchroniser for a level from another domain
// assumes: destination clock mclk, async active-low reset
`timescale 1ns/1ns
`default_nettype none
module eols_sync (
    // clock and reset
    input wire mclk,
    input wire arst_n,
    // level in and out
    input wire d,
    output reg q
);
    reg meta_q;
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // eols_sync
`default_nettype wire

// [testbench/eols_checker.sv]
// checker: trailer framing seen at eols_top ports
// assumes: bound into eols_top, one word per pix_clk edge
`timescale 1ns/1ns
`default_nettype none
module eols_checker #(parameter PIX_W = 12, parameter COL_W = 16) (
    input wire mclk,
    input wire arst_n,
    input wire pix_clk,
    input wire trailer_en,
    input wire lval_out,
    input wire [PIX_W-1:0] pix_out,
    input wire word_stb
);
    // hi_q: a line word was seen, so low words after it are a trailer
    logic hi_q;
    logic [4:0] n_q;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hi_q <= 1'b0;
            n_q <= 5'h00;
        end else if (word_stb) begin
            hi_q <= hi_q | lval_out;
            n_q <= lval_out ? 5'h00 : n_q + {4'h0, n_q != 5'h1f};
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence s_trl;
        word_stb && trailer_en && hi_q && !lval_out;
    endsequence
    pat_first_a: assert property (s_trl and n_q == 0 |-> pix_out == 12'h0aa) else $error("word1 bad");
    pat_second_a: assert property (s_trl and n_q == 1 |-> pix_out == 12'h055) else $error("word2 bad");
    pat_third_a: assert property (s_trl and n_q == 2 |-> pix_out == 12'h0aa) else $error("word3 bad");
    trl_upper_a: assert property (s_trl and n_q < 20 |-> pix_out[PIX_W-1:8] == '0) else $error("upper");
    trl_low_a: assert property (word_stb && trailer_en && hi_q && n_q != 0 && n_q < 20 |-> !lval_out)
        else $error("lval high in trailer");
    stb_pulse_a: assert property (word_stb |=> !word_stb [*8]) else $error("strobe too long");
    out_hold_a: assert property (!word_stb |-> $stable(pix_out) && $stable(lval_out)) else $error("moved");
    word_answer_a: assert property ($rose(pix_clk) |-> ##[1:6] word_stb) else $error("no word");
endmodule // eols_checker
bind eols_top eols_checker #(.PIX_W(PIX_W), .COL_W(COL_W)) chk (.mclk(mclk), .arst_n(arst_n),
    .pix_clk(pix_clk), .trailer_en(trailer_en), .lval_out(lval_out), .pix_out(pix_out), .word_stb(word_stb));
`default_nettype wire

// [testbench/eols_grabber.sv]
// grabber model: records every word the block sends
// assumes: word_stb marks a new word on lval_out and pix_out
`timescale 1ns/1ns
`default_nettype none
module eols_grabber #(parameter PIX_W = 12) (
    input wire mclk,
    input wire word_stb,
    input wire lval_out,
    input wire [PIX_W-1:0] pix_out
);
    logic [PIX_W:0] words[$];
    always @(posedge mclk) begin
        if (word_stb) words.push_back({lval_out, pix_out});
    end
endmodule // eols_grabber
`default_nettype wire

// [testbench/eols_top_tb_top.sv]
// bench: lines through eols_top, trailer words compared
// assumes: grabber model records output words
`timescale 1ns/1ns
`default_nettype none
module eols_top_tb_top;
    logic mclk = 0, arst_n = 0, pix_clk = 0, lval_in = 0, trailer_en = 1, area_mode = 0;
    logic [11:0] pix_in = 0, thr_upper = 0, thr_lower = 0;
    logic [15:0] roi_first = 16'h0002, roi_last = 16'h0009;
    wire lval_out, word_stb;
    wire [11:0] pix_out;
    int n_mismatch = 0, cmp_count = 0, cyc = 0;
    initial forever #5 mclk = ~mclk;
    // pixel clock runs free, phase unrelated to mclk; its edges never meet an
    // mclk edge, so sampling it carries no race
    initial begin #9; forever begin #63 pix_clk = 1; #62 pix_clk = 0; end end
    eols_top dut (.mclk(mclk), .arst_n(arst_n), .pix_clk(pix_clk), .lval_in(lval_in), .pix_in(pix_in),
        .trailer_en(trailer_en), .area_mode(area_mode), .thr_upper(thr_upper), .thr_lower(thr_lower),
        .roi_first(roi_first), .roi_last(roi_last), .lval_out(lval_out), .pix_out(pix_out), .word_stb(word_stb));
    eols_grabber g (.mclk(mclk), .word_stb(word_stb), .lval_out(lval_out), .pix_out(pix_out));
    function automatic logic [11:0] pv(input int i, input int sd); return 12'((i * 977 + sd * 1031) % 4096);
    endfunction
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic put(input logic lv, input logic [11:0] px);
        @(negedge pix_clk);
        @(negedge mclk);
        lval_in = lv;
        pix_in = px;
    endtask
    task automatic line(input int n, input int sd, input logic [3:0] c);
        logic [159:0] t;
        logic [39:0] s, d;
        logic [23:0] a, b;
        logic [11:0] p, q;
        int j;
        {s, d, a, b, q} = '0;
        g.words.delete();
        for (int i = 0; i < n; i++) begin
            p = pv(i, sd);
            put(1'b1, p);
            if (i >= roi_first && i <= roi_last) begin
                s += p;
                a += p > thr_upper;
                b += p < thr_lower;
                if (i > roi_first) d += p > q ? p - q : q - p;
                q = p;
            end
        end
        // idle words are a value no trailer word can take
        repeat (24) put(1'b0, 12'hc3c);
        t = {d, b, a, s, area_mode ? c : 4'h0, c, 24'haa55aa};
        for (j = 1; j < g.words.size() - 1; j++) if (g.words[j - 1][12] && !g.words[j][12]) break;
        for (int k = 0; k < 20; k++)
            chk(g.words[j + k], trailer_en ? {5'h00, t[8 * k +: 8]} : 13'h0c3c);
    endtask
    task conclude;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        repeat (4) @(negedge mclk);
        arst_n = 1;
        for (int i = 0; i < 18; i++) begin
            area_mode = i[0];
            thr_upper = i[0] ? 12'hfff : 12'h000;
            thr_lower = i[0] ? 12'h000 : 12'hfff;
            if (i == 2) thr_upper = pv(3, 2);
            if (i == 2) thr_lower = pv(4, 2);
            line(12, i, 4'(i));
        end
        trailer_en = 0;
        line(12, 18, 4'h2);
        conclude();
    end
endmodule // eols_top_tb_top
`default_nettype wire
